// ---- src/cat_defines.svh ----
`ifndef CAT_DEFINES_SVH
`define CAT_DEFINES_SVH
// Behaviour
// - Sixteen-bit counter read and written as separate high and low bytes.
// - Low byte read snapshots high byte; next high read returns the snapshot.
// - Counter reads never disturb counting.
// - Timebase codes: 0 sysclk/12, 1 sysclk/4, 2 timer 0 overflow, 4 sysclk.
// - Code 3 counts falling edges of external input, source kept below sysclk/4.
// - Wrap from all ones to zero sets overflow flag and may request interrupt.
// - Overflow interrupt enable gates the overflow flag onto the request.
// - Overflow flag is cleared only by a software write, never on vectoring.
// - With idle suspend clear the array keeps counting during processor idle.
// - Intermediate flag sets on carry into bit 8, 9, 10 or 11 as chosen.
// - Each of six channels owns an event flag set by its mode.
// - All flags set on their trigger regardless of their enables.
// - Each flag has its own enable; only enabled flags reach the request.
// - Request needs both global and array interrupt enables.
// - One shared counter and six 16-bit channels, each with its own line.
// - Each channel configurable as capture, timer or toggle; the PWM bit turns on the line driver and blocks toggling.
// - One shared 8 to 11 bit cycle-length setting drives the intermediate flag.
// - Channel 5 watchdog on after reset; restricts register writes while on.
// - Channel flags are cleared only by software.

// Register byte offsets
`define CAT_OFS_CNT_LO 8'h00
`define CAT_OFS_CNT_HI 8'h04
`define CAT_OFS_MODE 8'h08
`define CAT_OFS_FLAGS 8'h0c
`define CAT_OFS_PWM 8'h10
`define CAT_OFS_IEN 8'h14
`define CAT_OFS_CHMODE 8'h18
`define CAT_OFS_CHCMP 8'h30

// Mode register fields
`define CAT_MODE_IDLE 7
`define CAT_MODE_WD 6
`define CAT_MODE_TB_HI 3
`define CAT_MODE_TB_LO 1
`define CAT_MODE_OVFEN 0
`define CAT_MODE_MASK 8'hcf
`define CAT_MODE_RST 8'h40

// Flag register, pwm config and enable fields
`define CAT_FLG_CF 7
`define CAT_FLG_INTERMEDIATE_OVERFLOW_FLAG 6
`define CAT_PWM_COVFEN 5
`define CAT_PWM_MASK 8'h23
`define CAT_IEN_ARRAY 0
`define CAT_IEN_GLOBAL 1

// Prescaler terminal counts: divide by 12, 4 and 8
`define CAT_DIV12_LAST 4'hb
`define CAT_DIV4_LAST 2'h3
`define CAT_DIV8_LAST 3'h7

// Bus responses
`define CAT_RESP_OKAY 2'h0
`define CAT_RESP_SLVERR 2'h2
`endif

// ---- src/cat_pkg.sv ----
package cat_pkg;

  typedef enum logic [2:0] {
    CAT_TB_DIV12 = 3'h0,
    CAT_TB_DIV4 = 3'h1,
    CAT_TB_T0 = 3'h2,
    CAT_TB_ECI = 3'h3,
    CAT_TB_SYS = 3'h4,
    CAT_TB_EXT8 = 3'h5
  } cat_timebase_t;

  // Channel mode register, bits 6 down to 0
  typedef struct packed {
    logic ecom;
    logic capp;
    logic capn;
    logic mat;
    logic tog;
    logic pwm;
    logic eccf;
  } cat_chmode_t;

endpackage : cat_pkg

// ---- src/cat_channel.sv ----
`include "cat_defines.svh"

module cat_channel (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Shared counter
  input wire logic cnt_upd,
  input wire logic [15:0] cnt,
  // Configuration and value writes
  input wire cat_pkg::cat_chmode_t mode,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [7:0] wdata,
  // Line and results
  input wire logic io_in,
  output logic io_out,
  output logic io_oe_n,
  output logic [15:0] cmp_val,
  output logic event_pulse
);

  logic io_s1_r, io_s2_r, io_s3_r;
  logic rise, fall, capture, match;

  // Line sampled twice before edge detection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      io_s1_r <= 1'b0;
      io_s2_r <= 1'b0;
      io_s3_r <= 1'b0;
    end
    else if (ce)
    begin
      io_s1_r <= io_in;
      io_s2_r <= io_s1_r;
      io_s3_r <= io_s2_r;
    end
  end

  assign rise = io_s2_r & ~io_s3_r;
  assign fall = ~io_s2_r & io_s3_r;
  assign capture = (mode.capp & rise) | (mode.capn & fall);
  assign match = mode.ecom & cnt_upd & (cnt == cmp_val);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cmp_val <= 16'h0000;
    else if (ce)
    begin
      if (capture)
        cmp_val <= cnt;
      if (wr_lo)
        cmp_val[7:0] <= wdata;
      if (wr_hi)
        cmp_val[15:8] <= wdata;
    end
  end

  // Toggle on match in high-speed output mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      io_out <= 1'b0;
    else if (ce && match && mode.tog && !mode.pwm)
      io_out <= ~io_out;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      event_pulse <= 1'b0;
    else if (ce)
      event_pulse <= capture | (match & mode.mat);
  end

  assign io_oe_n = ~(mode.tog | mode.pwm);

endmodule : cat_channel

// ---- src/cat_counter_array.sv ----
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`include "cat_defines.svh"

module cat_counter_array #(
  parameter int AW = 8,
  parameter int NCH = 6
) (
  // Clock, reset, freeze
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AW-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [AW-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Timebase sources and processor state
  input wire logic cpu_idle,
  input wire logic timer0_ovf,
  input wire logic external_count_input,
  input wire logic ext_osc_in,
  // Channel lines
  input wire logic [NCH-1:0] channel_io_line_in,
  output logic [NCH-1:0] channel_io_line_out,
  output logic [NCH-1:0] channel_io_line_oe_n,
  // Combined request
  output logic array_irq
);

  // ------------------------------------------------------------
  // Decoding helpers
  // ------------------------------------------------------------
  function automatic logic [3:0] chan_sel(input logic [AW-1:0] a, input logic [AW-1:0] base);
    logic [AW-1:0] d;
    logic hit;
    d = a - base;
    hit = (a >= base) && (d[1:0] == 2'h0) && (int'(d[AW-1:2]) < NCH);
    chan_sel = {hit, d[4:2]};
  endfunction : chan_sel

  function automatic logic mapped(input logic [AW-1:0] a);
    logic [3:0] m;
    logic [3:0] c;
    m = chan_sel(a, `CAT_OFS_CHMODE);
    c = chan_sel(a, `CAT_OFS_CHCMP);
    mapped = (a == `CAT_OFS_CNT_LO) || (a == `CAT_OFS_CNT_HI) || (a == `CAT_OFS_MODE) ||
             (a == `CAT_OFS_FLAGS) || (a == `CAT_OFS_PWM) || (a == `CAT_OFS_IEN) || m[3] || c[3];
  endfunction : mapped

  function automatic logic [15:0] cl_mask(input logic [1:0] sel);
    case (sel)
      2'h0: cl_mask = 16'h00ff;
      2'h1: cl_mask = 16'h01ff;
      2'h2: cl_mask = 16'h03ff;
      default: cl_mask = 16'h07ff;
    endcase
  endfunction : cl_mask

  // ------------------------------------------------------------
  // Register bus: write path
  // ------------------------------------------------------------
  logic aw_hold_r, w_hold_r, bvalid_r;
  logic [AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r;
  logic do_wr;

  assign s_axi_awready = ce & ~aw_hold_r & ~bvalid_r;
  assign s_axi_wready = ce & ~w_hold_r & ~bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign do_wr = ce & aw_hold_r & w_hold_r & ~bvalid_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      bvalid_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bresp_r <= `CAT_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= mapped(awaddr_r) ? `CAT_RESP_OKAY : `CAT_RESP_SLVERR;
      end
      else if (bvalid_r && s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  // Byte-lane qualified write strobes
  logic wr_b0, wr_b1;
  logic wr_lo, wr_hi, wr_mode, wr_flags, wr_pwm, wr_ien;
  logic [3:0] wsel_m, wsel_c;

  assign wr_b0 = do_wr & wstrb_r[0];
  assign wr_b1 = do_wr & wstrb_r[1];
  assign wr_lo = wr_b0 & (awaddr_r == `CAT_OFS_CNT_LO);
  assign wr_hi = wr_b0 & (awaddr_r == `CAT_OFS_CNT_HI);
  assign wr_mode = wr_b0 & (awaddr_r == `CAT_OFS_MODE);
  assign wr_flags = wr_b0 & (awaddr_r == `CAT_OFS_FLAGS);
  assign wr_pwm = wr_b0 & (awaddr_r == `CAT_OFS_PWM);
  assign wr_ien = wr_b0 & (awaddr_r == `CAT_OFS_IEN);
  assign wsel_m = chan_sel(awaddr_r, `CAT_OFS_CHMODE);
  assign wsel_c = chan_sel(awaddr_r, `CAT_OFS_CHCMP);

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [7:0] mode_r, pwm_r;
  logic [1:0] ien_r;
  cat_pkg::cat_chmode_t chmode_r [NCH];
  logic wd_on;

  assign wd_on = mode_r[`CAT_MODE_WD];

  // While the watchdog is on only its own bit may change here
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_r <= `CAT_MODE_RST;
    else if (ce && wr_mode)
    begin
      if (wd_on)
        mode_r[`CAT_MODE_WD] <= wdata_r[`CAT_MODE_WD];
      else
        mode_r <= wdata_r[7:0] & `CAT_MODE_MASK;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pwm_r <= 8'h00;
      ien_r <= 2'h0;
    end
    else if (ce)
    begin
      if (wr_pwm)
        pwm_r <= wdata_r[7:0] & `CAT_PWM_MASK;
      if (wr_ien)
        ien_r <= wdata_r[1:0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < NCH; i++)
        chmode_r[i] <= '0;
    end
    else if (ce && wr_b0 && wsel_m[3])
    begin
      for (int i = 0; i < NCH; i++)
        if (int'(wsel_m[2:0]) == i && !(wd_on && i == NCH - 1))
          chmode_r[i] <= cat_pkg::cat_chmode_t'(wdata_r[6:0]);
    end
  end

  // ------------------------------------------------------------
  // Timebase
  // ------------------------------------------------------------
  logic [3:0] div12_r;
  logic [1:0] div4_r;
  logic [2:0] ext_div_r;
  logic eci_s1_r, eci_s2_r, eci_s3_r;
  logic ext_s1_r, ext_s2_r, ext_s3_r;
  logic eci_fall, ext_tick, tb_tick, cnt_tick;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div12_r <= 4'h0;
      div4_r <= 2'h0;
    end
    else if (ce)
    begin
      div12_r <= (div12_r == `CAT_DIV12_LAST) ? 4'h0 : div12_r + 4'h1;
      div4_r <= (div4_r == `CAT_DIV4_LAST) ? 2'h0 : div4_r + 2'h1;
    end
  end

  // Both pin sources pass two flops before any edge logic
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      eci_s1_r <= 1'b0;
      eci_s2_r <= 1'b0;
      eci_s3_r <= 1'b0;
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end
    else if (ce)
    begin
      eci_s1_r <= external_count_input;
      eci_s2_r <= eci_s1_r;
      eci_s3_r <= eci_s2_r;
      ext_s1_r <= ext_osc_in;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  // Falling edges faster than sysclk/4 may merge after the sync
  assign eci_fall = ~eci_s2_r & eci_s3_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ext_div_r <= 3'h0;
    else if (ce && ext_s2_r && !ext_s3_r)
      ext_div_r <= ext_div_r + 3'h1;
  end

  assign ext_tick = ext_s2_r & ~ext_s3_r & (ext_div_r == `CAT_DIV8_LAST);

  always_comb
  begin
    case (cat_pkg::cat_timebase_t'(mode_r[`CAT_MODE_TB_HI:`CAT_MODE_TB_LO]))
      cat_pkg::CAT_TB_DIV12: tb_tick = (div12_r == `CAT_DIV12_LAST);
      cat_pkg::CAT_TB_DIV4: tb_tick = (div4_r == `CAT_DIV4_LAST);
      cat_pkg::CAT_TB_T0: tb_tick = timer0_ovf;
      cat_pkg::CAT_TB_ECI: tb_tick = eci_fall;
      cat_pkg::CAT_TB_SYS: tb_tick = 1'b1;
      cat_pkg::CAT_TB_EXT8: tb_tick = ext_tick;
      default: tb_tick = 1'b0;
    endcase
  end

  // Idle only stops the array when software asked for it
  assign cnt_tick = tb_tick & ~(cpu_idle & mode_r[`CAT_MODE_IDLE]);

  // ------------------------------------------------------------
  // Counter and overflow events
  // ------------------------------------------------------------
  logic [15:0] cnt_r;
  logic cnt_upd_r;
  logic ovf_evt, intermediate_overflow_flag_evt;
  logic [15:0] cmask;

  assign cmask = cl_mask(pwm_r[1:0]);
  assign ovf_evt = cnt_tick & (cnt_r == 16'hffff);
  assign intermediate_overflow_flag_evt = cnt_tick & ((cnt_r & cmask) == cmask);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_r <= 16'h0000;
    else if (ce)
    begin
      if (cnt_tick)
        cnt_r <= cnt_r + 16'h0001;
      if (wr_lo && !wd_on)
        cnt_r[7:0] <= wdata_r[7:0];
      if (wr_hi && !wd_on)
        cnt_r[15:8] <= wdata_r[7:0];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_upd_r <= 1'b0;
    else if (ce)
      cnt_upd_r <= cnt_tick | wr_lo | wr_hi;
  end

  // ------------------------------------------------------------
  // Channels
  // ------------------------------------------------------------
  logic [NCH-1:0] ch_evt;
  logic [NCH-1:0] ch_irq_en;
  logic [15:0] ch_val [NCH];

  generate
    for (genvar g = 0; g < NCH; g++)
    begin : g_ch
      assign ch_irq_en[g] = chmode_r[g].eccf;
      cat_channel u_ch (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .cnt_upd(cnt_upd_r),
        .cnt(cnt_r),
        .mode(chmode_r[g]),
        .wr_lo(wr_b0 && wsel_c[3] && int'(wsel_c[2:0]) == g),
        .wr_hi(wr_b1 && wsel_c[3] && int'(wsel_c[2:0]) == g),
        .wdata(wstrb_r[0] ? wdata_r[7:0] : wdata_r[15:8]),
        .io_in(channel_io_line_in[g]),
        .io_out(channel_io_line_out[g]),
        .io_oe_n(channel_io_line_oe_n[g]),
        .cmp_val(ch_val[g]),
        .event_pulse(ch_evt[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Event flags and request
  // ------------------------------------------------------------
  logic cf_r, intermediate_overflow_flag_r;
  logic [NCH-1:0] chf_r;
  logic clr_cf, clr_intermediate_overflow_flag;
  logic [NCH-1:0] clr_ch;

  // Writing zero clears a flag; a same-cycle event wins
  assign clr_cf = wr_flags & ~wdata_r[`CAT_FLG_CF];
  assign clr_intermediate_overflow_flag = wr_flags & ~wdata_r[`CAT_FLG_INTERMEDIATE_OVERFLOW_FLAG];
  assign clr_ch = {NCH{wr_flags}} & ~wdata_r[NCH-1:0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cf_r <= 1'b0;
      intermediate_overflow_flag_r <= 1'b0;
      chf_r <= '0;
    end
    else if (ce)
    begin
      cf_r <= ovf_evt | (cf_r & ~clr_cf);
      intermediate_overflow_flag_r <= intermediate_overflow_flag_evt | (intermediate_overflow_flag_r & ~clr_intermediate_overflow_flag);
      chf_r <= ch_evt | (chf_r & ~clr_ch);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      array_irq <= 1'b0;
    else if (ce)
      array_irq <= ien_r[`CAT_IEN_GLOBAL] & ien_r[`CAT_IEN_ARRAY] &
                   ((cf_r & mode_r[`CAT_MODE_OVFEN]) |
                    (intermediate_overflow_flag_r & pwm_r[`CAT_PWM_COVFEN]) | (|(chf_r & ch_irq_en)));
  end

  // ------------------------------------------------------------
  // Register bus: read path
  // ------------------------------------------------------------
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [7:0] snap_r;
  logic [31:0] rd_mux;
  logic [3:0] rsel_m, rsel_c;
  logic rd_take;

  assign s_axi_arready = ce & ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign rd_take = s_axi_arvalid & s_axi_arready;
  assign rsel_m = chan_sel(s_axi_araddr, `CAT_OFS_CHMODE);
  assign rsel_c = chan_sel(s_axi_araddr, `CAT_OFS_CHCMP);

  always_comb
  begin
    rd_mux = 32'h00000000;
    if (s_axi_araddr == `CAT_OFS_CNT_LO)
      rd_mux[7:0] = cnt_r[7:0];
    else if (s_axi_araddr == `CAT_OFS_CNT_HI)
      rd_mux[7:0] = snap_r;
    else if (s_axi_araddr == `CAT_OFS_MODE)
      rd_mux[7:0] = mode_r;
    else if (s_axi_araddr == `CAT_OFS_FLAGS)
      rd_mux[7:0] = {cf_r, intermediate_overflow_flag_r, chf_r};
    else if (s_axi_araddr == `CAT_OFS_PWM)
      rd_mux[7:0] = pwm_r;
    else if (s_axi_araddr == `CAT_OFS_IEN)
      rd_mux[1:0] = ien_r;
    else if (rsel_m[3])
      rd_mux[6:0] = chmode_r[rsel_m[2:0]];
    else if (rsel_c[3])
      rd_mux[15:0] = ch_val[rsel_c[2:0]];
  end

  // Reads touch only the snapshot, never the counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      snap_r <= 8'h00;
    else if (ce && rd_take && s_axi_araddr == `CAT_OFS_CNT_LO)
      snap_r <= cnt_r[15:8];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `CAT_RESP_OKAY;
    end
    else if (ce)
    begin
      if (rd_take)
      begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= mapped(s_axi_araddr) ? `CAT_RESP_OKAY : `CAT_RESP_SLVERR;
      end
      else if (rvalid_r && s_axi_rready)
        rvalid_r <= 1'b0;
    end
  end

endmodule : cat_counter_array

// ---- sim/cat_counter_array_monitor.sv ----
module cat_counter_array_monitor #(
  parameter int AW = 8,
  parameter int NCH = 6
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Lines and request
  input wire logic [NCH-1:0] channel_io_line_out,
  input wire logic [NCH-1:0] channel_io_line_oe_n,
  input wire logic array_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing after address");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("bad write response code");
  wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  freeze_bus_a: assert property (!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("bus ready while frozen");
  freeze_out_a: assert property (!ce |=> $stable(array_irq) && $stable(channel_io_line_out))
    else $error("outputs moved while frozen");
  reset_quiet_a: assert property ($rose(aresetn) |-> !array_irq && (&channel_io_line_oe_n))
    else $error("outputs active after reset");
  irq_sticky_a: assert property ($fell(array_irq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("request dropped without software write");
endmodule : cat_counter_array_monitor

bind cat_counter_array cat_counter_array_monitor #(.AW(AW), .NCH(NCH)) i_cat_counter_array_monitor (.aclk, .aresetn,
  .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .channel_io_line_out,
  .channel_io_line_oe_n, .array_irq);

// ---- sim/test_counter_array_timebase_irq.sv ----
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; $display("unexpected at %0t got %h exp %h", $time, g, e); end end

module test_counter_array_timebase_irq;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, ce = 1, cpu_idle = 0, timer0_ovf = 0, external_count_input = 1, ext_osc_in = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic [5:0] channel_io_line_in = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, array_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd_v;
  logic [5:0] channel_io_line_out, channel_io_line_oe_n;
  logic [7:0] l1, h1, l2;
  int err_count = 0, compares = 0, cyc = 0, t0_n = 0, ar_cyc, ar_t0, c1, c2, n;

  cat_counter_array i_cat_counter_array (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .cpu_idle, .timer0_ovf, .external_count_input, .ext_osc_in, .channel_io_line_in, .channel_io_line_out,
    .channel_io_line_oe_n, .array_irq);

  initial forever #20 aclk = ~aclk;

  // Count sources: eci falls every 8 cycles, oscillator rises every 6
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (timer0_ovf) t0_n <= t0_n + 1;
    timer0_ovf <= ($urandom_range(4) == 0);
    external_count_input <= ~cyc[2];
    ext_osc_in <= (cyc % 6) < 3;
    channel_io_line_in <= 6'($urandom);
  end

  // Ready sampled at the falling edge, acted on at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1);
    logic aw_t, w_t, b_t;
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    b_t = 0;
    for (k = 0; k < 100 && !b_t; k++)
    begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 0;
      if (w_t) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
    if (!b_t) err_count++;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic ar_t, r_t;
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    r_t = 0;
    for (k = 0; k < 100 && !r_t; k++)
    begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid;
      rd_v = s_axi_rdata;
      rsp = s_axi_rresp;
      if (ar_t) ar_cyc = cyc;
      if (ar_t) ar_t0 = t0_n;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
    if (!r_t) err_count++;
  endtask : rd

  // Counter loaded while the timebase is parked on a reserved code
  task automatic setcnt(input logic [15:0] v);
    wr(8'h08, 32'h0c);
    wr(8'h04, {24'h0, v[15:8]});
    wr(8'h00, {24'h0, v[7:0]});
    wr(8'h0c, 32'h0);
  endtask : setcnt

  function automatic int exp_delta(input logic [2:0] code, input logic sus, input int dc, input int dt);
    case (code)
      3'h0: return dc / 12;
      3'h1: return dc / 4;
      3'h2: return dt;
      3'h3: return dc / 8;
      3'h4: return sus ? 0 : dc;
      3'h5: return dc / 48;
      default: return 0;
    endcase
  endfunction : exp_delta

  task automatic tb_run(input logic [2:0] code, input logic sus);
    logic [7:0] v1;
    int t1, e, tol, d;
    wr(8'h08, {24'h0, sus, 3'h0, code, 1'b0});
    rd(8'h00);
    v1 = rd_v[7:0];
    c1 = ar_cyc;
    t1 = ar_t0;
    repeat (code == 3'h4 ? 200 : 960) @(posedge aclk);
    rd(8'h00);
    d = 8'(rd_v[7:0] - v1);
    e = exp_delta(code, sus, ar_cyc - c1, ar_t0 - t1);
    tol = (code == 3'h3 || code == 3'h5) ? 2 : (code >= 3'h4 ? 0 : 1);
    `CHK((d >= e - tol && d <= e + tol), 1'b1)
    $display("timebase %0d idle stop %0d done", code, sus);
  endtask : tb_run

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    #2400000;
    err_count++;
    tally_and_finish();
  end

  initial
  begin
    void'($urandom(32'h5f83b2c5));
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    rd(8'h08);
    `CHK(rd_v, 32'h40)
    wr(8'h08, 32'h08);
    rd(8'h08);
    `CHK(rd_v, 32'h0)
    rd(8'hfc);
    `CHK(rsp, 2'h2)
    wr(8'hfc, 32'hff);
    `CHK(rsp, 2'h2)
    $display("reset and map done");
    cpu_idle <= 1;
    for (n = 0; n < 8; n++) tb_run(3'(n), 1'b0);
    tb_run(3'h4, 1'b1);
    // Snapshot: live high byte moves on between the two reads
    setcnt(16'h12f0);
    wr(8'h08, 32'h08);
    rd(8'h00);
    l1 = rd_v[7:0];
    c1 = ar_cyc;
    repeat (300) @(posedge aclk);
    ce <= 0;
    repeat (20) @(posedge aclk);
    ce <= 1;
    rd(8'h04);
    h1 = (l1 >= 8'hf0) ? 8'h12 : 8'h13;
    `CHK(rd_v[7:0], h1)
    // Full word advanced by every enabled edge, frozen ones excluded
    rd(8'h00);
    l2 = rd_v[7:0];
    c2 = ar_cyc;
    rd(8'h04);
    `CHK({rd_v[7:0], l2}, 16'({h1, l1} + c2 - c1 - 20))
    $display("snapshot done");
    // Overflow: both flags set, enable tree, software clear
    setcnt(16'hfff0);
    wr(8'h14, 32'h1);
    wr(8'h08, 32'h09);
    repeat (40) @(posedge aclk);
    rd(8'h0c);
    `CHK(rd_v, 32'hc0)
    @(negedge aclk);
    `CHK(array_irq, 1'b0)
    wr(8'h14, 32'h3);
    repeat (2) @(negedge aclk);
    `CHK(array_irq, 1'b1)
    wr(8'h0c, 32'h3f);
    repeat (2) @(negedge aclk);
    `CHK(array_irq, 1'b0)
    rd(8'h0c);
    `CHK(rd_v, 32'h0)
    $display("overflow done");
    // Channel 0 as toggling software timer matching at 0x0080
    setcnt(16'h0000);
    wr(8'h30, 32'h80);
    wr(8'h18, 32'h4d);
    @(negedge aclk);
    `CHK(channel_io_line_oe_n, 6'h3e)
    wr(8'h08, 32'h08);
    repeat (200) @(posedge aclk);
    rd(8'h0c);
    `CHK(rd_v, 32'h01)
    @(negedge aclk);
    `CHK(channel_io_line_out, 6'h01)
    `CHK(array_irq, 1'b1)
    $display("channel done");
    tally_and_finish();
  end
endmodule : test_counter_array_timebase_irq
